// *** sdc_cfg.svh ***
`ifndef SDC_CFG_SVH
`define SDC_CFG_SVH

// Positions of the asynchronous pin inputs in the synchroniser vector.
`define SDC_SYNC_W 5
`define SDC_IX_CALREQ 0
`define SDC_IX_TB 1
`define SDC_IX_IO 2
`define SDC_IX_TRIP 3
`define SDC_IX_FB 4

// Timebase edges that make one full timebase cycle.
`define SDC_QUAL_EDGES 2'h2

// Silence timer test pattern: low for 8 of every 128 timebase cycles.
`define SDC_LED_CNT_W 7
`define SDC_LED_ON_CYCLES 7'h08

// Silence timer in normal operation, counted in timebase cycles.
`define SDC_SIL_W 16
`define SDC_SIL_MINUTES 8
`define SDC_TB_PERIOD_US 7900
`define SDC_SIL_CYCLES ((`SDC_SIL_MINUTES * 60 * 1000000) / `SDC_TB_PERIOD_US)

`endif

// *** sdc_pkg.sv ***
`include "sdc_cfg.svh"

package sdc_pkg;

    typedef enum logic {SDC_NORMAL, SDC_CAL} sdc_mode_e;

    typedef logic [`SDC_SYNC_W-1:0] sdc_sync_t;

    typedef struct packed {
        sdc_sync_t sy1;
        sdc_sync_t sy2;
        sdc_sync_t sy3;
        sdc_sync_t flt;
        logic tb_prev;
        sdc_mode_e mode;
        logic [1:0] qual_cnt;
        logic [`SDC_SIL_W-1:0] sil_cnt;
        logic emit_r;
        logic strobe_n_r;
        logic led_on_r;
        logic horn1_r;
        logic horn2_r;
        logic silenced_r;
        logic route_r;
        logic gain_r;
        logic amp_test_r;
        logic hyst_r;
        logic low_supply_r;
    } sdc_state_s;

    localparam sdc_state_s SDC_ST_RST = '{strobe_n_r: 1'b1, mode: SDC_NORMAL, default: '0};

endpackage

// *** sdc_calib.sv ***
// Notes on behaviour
// - Calibration entered after request held through one full timebase cycle.
// - Calibration left after request released through one full timebase cycle.
// - Emitter drive pulses once every timebase cycle in calibration.
// - Strobe held active low throughout calibration, so low whenever clock low.
// - Emitter drive follows the timebase pin level in calibration.
// - LED pulses low for 8 of every 128 timebase cycles in calibration.
// - First horn electrode shows the smoke latch in calibration.
// - Second horn electrode shows the photo comparator in calibration.
// - I/O pin low in calibration disables amplifier, feedback, supply-trip test pins.
// - I/O pin high in calibration routes photo amplifier and enables test pins.
// - With routing, supply-trip input selects gain, not low supply; I/O pin selects routing.
// - LED pattern exercises the roughly eight minute silence timer.
`include "sdc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module sdc_calib
    import sdc_pkg::*;
#(
    parameter logic [`SDC_SIL_W-1:0] SIL_CYCLES = `SDC_SIL_W'(`SDC_SIL_CYCLES)
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Asynchronous pin levels.
    input wire logic cal_request,
    input wire logic timebase_capacitor_pin,
    input wire logic io_pin,
    input wire logic supply_trip_input,
    input wire logic feedback_in,
    // Internal detector state on this clock.
    input wire logic smoke_latch,
    input wire logic photo_comp,
    input wire logic photo_amp_level,
    input wire logic silence_start,
    // Normal-mode drive from the standby logic.
    input wire logic norm_emitter,
    input wire logic norm_strobe_n,
    input wire logic norm_led_on,
    input wire logic norm_horn_first,
    input wire logic norm_horn_second,
    // Pin drive.
    output logic emitter_drive_output,
    output logic strobe_n,
    output logic led_out,
    output logic led_oe,
    output logic horn_electrode_first,
    output logic horn_electrode_second,
    // Test routing and status.
    output logic cal_mode,
    output logic route_enable,
    output logic gain_select,
    output logic amp_test_out,
    output logic hysteresis_ctrl,
    output logic low_supply_alarm,
    output logic horn_silenced
);

    sdc_state_s st_q;
    sdc_state_s st_d;

    logic tb_rise;
    logic in_cal;
    logic routed;

    always_comb begin
        st_d = st_q;
        st_d.sy1 = {feedback_in, supply_trip_input, io_pin, timebase_capacitor_pin, cal_request};
        st_d.sy2 = st_q.sy1;
        st_d.sy3 = st_q.sy2;
        for (int i = 0; i < `SDC_SYNC_W; i++) begin
            if (st_q.sy2[i] == st_q.sy3[i]) begin
                st_d.flt[i] = st_q.sy2[i];
            end
        end
        tb_rise = st_q.flt[`SDC_IX_TB] & ~st_q.tb_prev;
        st_d.tb_prev = st_q.flt[`SDC_IX_TB];

        // Mode change needs two timebase rises with the request steady.
        case (st_q.mode)
            SDC_NORMAL: begin
                if (!st_q.flt[`SDC_IX_CALREQ]) begin
                    st_d.qual_cnt = 2'h0;
                end else if (tb_rise) begin
                    if (st_q.qual_cnt + 2'h1 == `SDC_QUAL_EDGES) begin
                        st_d.mode = SDC_CAL;
                        st_d.qual_cnt = 2'h0;
                        st_d.sil_cnt = '0;
                    end else begin
                        st_d.qual_cnt = st_q.qual_cnt + 2'h1;
                    end
                end
            end
            SDC_CAL: begin
                if (st_q.flt[`SDC_IX_CALREQ]) begin
                    st_d.qual_cnt = 2'h0;
                end else if (tb_rise) begin
                    if (st_q.qual_cnt + 2'h1 == `SDC_QUAL_EDGES) begin
                        st_d.mode = SDC_NORMAL;
                        st_d.qual_cnt = 2'h0;
                        st_d.sil_cnt = '0;
                    end else begin
                        st_d.qual_cnt = st_q.qual_cnt + 2'h1;
                    end
                end
            end
            default: begin
                st_d.mode = SDC_NORMAL;
                st_d.qual_cnt = 2'h0;
            end
        endcase

        in_cal = (st_q.mode == SDC_CAL);
        routed = in_cal & st_q.flt[`SDC_IX_IO];

        // Silence timer: free-runs in calibration, counts down after silencing otherwise.
        if (in_cal && st_d.mode == SDC_CAL) begin
            if (tb_rise) begin
                st_d.sil_cnt = st_q.sil_cnt + `SDC_SIL_W'(1);
            end
        end else if (!in_cal && st_d.mode == SDC_NORMAL) begin
            // Skipped on the entry cycle so the zeroed pattern counter is not overwritten.
            if (silence_start) begin
                st_d.sil_cnt = SIL_CYCLES;
            end else if (tb_rise && st_q.sil_cnt != '0) begin
                st_d.sil_cnt = st_q.sil_cnt - `SDC_SIL_W'(1);
            end
        end

        if (in_cal) begin
            st_d.emit_r = st_q.flt[`SDC_IX_TB];
            st_d.strobe_n_r = 1'b0;
            st_d.led_on_r = (st_q.sil_cnt[`SDC_LED_CNT_W-1:0] < `SDC_LED_ON_CYCLES);
            st_d.horn1_r = smoke_latch;
            st_d.horn2_r = photo_comp;
            st_d.silenced_r = 1'b0;
            st_d.low_supply_r = 1'b0;
        end else begin
            st_d.emit_r = norm_emitter;
            st_d.strobe_n_r = norm_strobe_n;
            st_d.led_on_r = norm_led_on;
            st_d.horn1_r = norm_horn_first;
            st_d.horn2_r = norm_horn_second;
            st_d.silenced_r = (st_q.sil_cnt != '0);
            st_d.low_supply_r = st_q.flt[`SDC_IX_TRIP];
        end

        st_d.route_r = routed;
        st_d.gain_r = routed & st_q.flt[`SDC_IX_TRIP];
        st_d.amp_test_r = routed & photo_amp_level;
        st_d.hyst_r = routed & st_q.flt[`SDC_IX_FB];
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_q <= SDC_ST_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign emitter_drive_output = st_q.emit_r;
    assign strobe_n = st_q.strobe_n_r;
    assign led_out = 1'b0;
    assign led_oe = st_q.led_on_r;
    assign horn_electrode_first = st_q.horn1_r;
    assign horn_electrode_second = st_q.horn2_r;
    assign cal_mode = (st_q.mode == SDC_CAL);
    assign route_enable = st_q.route_r;
    assign gain_select = st_q.gain_r;
    assign amp_test_out = st_q.amp_test_r;
    assign hysteresis_ctrl = st_q.hyst_r;
    assign low_supply_alarm = st_q.low_supply_r;
    assign horn_silenced = st_q.silenced_r;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    sequence s_enter_cal;
        (st_q.mode == SDC_NORMAL) ##1 (st_q.mode == SDC_CAL);
    endsequence

    sequence s_leave_cal;
        (st_q.mode == SDC_CAL) ##1 (st_q.mode == SDC_NORMAL);
    endsequence

    a_enter_needs_request: assert property (
        s_enter_cal |-> $past(st_q.flt[`SDC_IX_CALREQ]) && $past(tb_rise)
    ) else $error("calibration entered without held request and timebase edge");

    a_leave_needs_release: assert property (
        s_leave_cal |-> !$past(st_q.flt[`SDC_IX_CALREQ]) && $past(tb_rise)
    ) else $error("calibration left without released request and timebase edge");

    a_no_entry_idle: assert property (
        (st_q.mode == SDC_NORMAL && !st_q.flt[`SDC_IX_CALREQ]) |=> st_q.mode == SDC_NORMAL
    ) else $error("calibration entered while request absent");

    a_emit_follows_tb: assert property (
        (st_q.mode == SDC_CAL) [*2] |-> emitter_drive_output == $past(st_q.flt[`SDC_IX_TB])
    ) else $error("emitter drive does not follow timebase level");

    a_strobe_held_low: assert property (
        (st_q.mode == SDC_CAL) |=> !strobe_n
    ) else $error("strobe not low in calibration");

    a_led_on_window: assert property (
        (st_q.mode == SDC_CAL && st_q.sil_cnt[`SDC_LED_CNT_W-1:0] >= `SDC_LED_ON_CYCLES)
            |=> !led_oe
    ) else $error("led lit outside its eight cycle window");

    a_led_lit_window: assert property (
        (st_q.mode == SDC_CAL && st_q.sil_cnt[`SDC_LED_CNT_W-1:0] < `SDC_LED_ON_CYCLES)
            |=> led_oe && !led_out
    ) else $error("led dark inside its eight cycle window");

    a_horn_first_latch: assert property (
        (st_q.mode == SDC_CAL) |=> horn_electrode_first == $past(smoke_latch)
    ) else $error("first horn electrode does not show smoke latch");

    a_horn_second_comp: assert property (
        (st_q.mode == SDC_CAL) |=> horn_electrode_second == $past(photo_comp)
    ) else $error("second horn electrode does not show comparator");

    a_routing_off_low: assert property (
        (st_q.mode == SDC_CAL && !st_q.flt[`SDC_IX_IO]) |=> !route_enable && !gain_select
    ) else $error("test routing active with io pin low");

    a_gain_from_trip: assert property (
        route_enable |-> gain_select == $past(st_q.flt[`SDC_IX_TRIP]) && !low_supply_alarm
    ) else $error("gain select does not follow supply trip input");

    a_amp_routed_high: assert property (
        (st_q.mode == SDC_CAL && st_q.flt[`SDC_IX_IO]) |=> route_enable
            && amp_test_out == $past(photo_amp_level)
            && hysteresis_ctrl == $past(st_q.flt[`SDC_IX_FB])
    ) else $error("photo amplifier not routed with io pin high");

    a_normal_restored: assert property (
        (st_q.mode == SDC_NORMAL) |=> emitter_drive_output == $past(norm_emitter)
            && strobe_n == $past(norm_strobe_n)
    ) else $error("normal drive not restored outside calibration");

endmodule // sdc_calib

`default_nettype wire

// *** sdc_fixture.sv ***
`timescale 1ns/1ns
`default_nettype none

module sdc_fixture (
    // Clock and reset.
    input wire logic clk,
    input wire logic srst,
    // Control from the bench.
    input wire logic want_cal,
    input wire logic [7:0] half,
    // Pins driven into the device, and the timebase phase count for the bench.
    output logic cal_request,
    output logic timebase_capacitor_pin,
    output logic [7:0] phase
);
    // The forced timebase runs free; the request follows want_cal one clock later.
    always_ff @(posedge clk) begin
        if (srst) begin
            phase <= 8'h00;
            timebase_capacitor_pin <= 1'b0;
            cal_request <= 1'b0;
        end else begin
            cal_request <= want_cal;
            phase <= (phase == half - 8'h01) ? 8'h00 : phase + 8'h01;
            if (phase == half - 8'h01) begin
                timebase_capacitor_pin <= ~timebase_capacitor_pin;
            end
        end
    end
endmodule // sdc_fixture

`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module tb_top;
    import sdc_pkg::*;
    logic clk, srst, want_cal, io, trip, fb, latch, comp, amp, sil, ne, nsn, nl, nh1, nh2;
    logic req, tbp, emit, stb_n, led, led_oe, h1, h2, cal, rte, gain, ampt, hyst, lowb, hsil;
    logic [7:0] ph;
    logic [31:0] rs;
    int errors, checks_done, lit, rises;

    sdc_fixture fix (.clk(clk), .srst(srst), .want_cal(want_cal), .half(8'h0C),
        .cal_request(req), .timebase_capacitor_pin(tbp), .phase(ph));

    sdc_calib #(.SIL_CYCLES(16'h0014)) uut (.clk(clk), .srst(srst), .cal_request(req),
        .timebase_capacitor_pin(tbp), .io_pin(io), .supply_trip_input(trip),
        .feedback_in(fb), .smoke_latch(latch), .photo_comp(comp), .photo_amp_level(amp),
        .silence_start(sil), .norm_emitter(ne), .norm_strobe_n(nsn), .norm_led_on(nl),
        .norm_horn_first(nh1), .norm_horn_second(nh2), .emitter_drive_output(emit),
        .strobe_n(stb_n), .led_out(led), .led_oe(led_oe), .horn_electrode_first(h1),
        .horn_electrode_second(h2), .cal_mode(cal), .route_enable(rte), .gain_select(gain),
        .amp_test_out(ampt), .hysteresis_ctrl(hyst), .low_supply_alarm(lowb),
        .horn_silenced(hsil));

    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic routed(input logic en, input logic v);
        return en & v;
    endfunction

    task automatic chk(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wait_mid();
        do begin
            @(posedge clk);
            #1;
        end while (ph !== 8'h08);
    endtask

    task automatic wait_mode(input logic v);
        for (int i = 0; i < 300 && cal !== v; i++) @(posedge clk);
        #1;
    endtask

    always @(posedge emit) rises++;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        #200000;
        errors++;
        end_of_test();
    end

    initial begin
        {srst, want_cal, io, trip, fb, latch, comp, amp, sil, ne, nsn, nl, nh1, nh2} = 14'h2000;
        rs = 32'h0000_0020;
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        want_cal <= 1'b1;
        repeat (30) @(posedge clk);
        #1;
        chk(cal, 1'b0, "mode entered before a full timebase cycle");
        wait_mode(1'b1);
        chk(cal, 1'b1, "calibration not entered");
        wait_mid();
        rises = 0;
        for (int k = 0; k < 256; k++) begin
            chk(emit, tbp, "emitter does not follow timebase");
            chk(stb_n, 1'b0, "strobe not low");
            chk(h1, latch, "first horn not smoke latch");
            chk(h2, comp, "second horn not comparator");
            chk(rte, io, "routing enable wrong");
            chk(ampt, routed(io, amp), "amp test output wrong");
            chk(hyst, routed(io, fb), "hysteresis control wrong");
            chk(gain, routed(io, trip), "gain select wrong");
            chk(lowb, 1'b0, "low supply alarm in calibration");
            chk(hsil, 1'b0, "silence started in calibration");
            chk(led, 1'b0, "led data not low");
            if (tbp === 1'b1 && led_oe === 1'b1) lit++;
            rs = xs(rs);
            @(posedge clk);
            {latch, comp, io, trip, fb, amp, sil} <= rs[6:0];
            @(posedge clk);
            sil <= 1'b0;
            wait_mid();
        end
        chk(rises == 128, 1'b1, "emitter pulse count");
        chk(lit == 8, 1'b1, "led lit cycle count");
        $display("test calibration done");
        @(posedge clk);
        want_cal <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
        chk(cal, 1'b1, "mode left before a full timebase cycle");
        wait_mode(1'b0);
        chk(cal, 1'b0, "calibration not left");
        @(posedge clk);
        {ne, nsn, nl, nh1, nh2, trip} <= 6'h2B;
        repeat (8) @(posedge clk);
        #1;
        chk(emit, ne, "emitter not normal");
        chk(stb_n, nsn, "strobe not normal");
        chk(led_oe, nl, "led not normal");
        chk(h1, nh1, "first horn not normal");
        chk(h2, nh2, "second horn not normal");
        chk(rte, 1'b0, "routing left enabled");
        chk(gain, 1'b0, "gain select left enabled");
        chk(ampt, 1'b0, "amp test output left enabled");
        chk(hyst, 1'b0, "hysteresis control left enabled");
        chk(lowb, trip, "low supply compare not restored");
        $display("test exit done");
        @(posedge clk);
        sil <= 1'b1;
        @(posedge clk);
        sil <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk(hsil, 1'b1, "silence timer not started");
        repeat (440) @(posedge clk);
        #1;
        chk(hsil, 1'b1, "silence timer expired early");
        repeat (88) @(posedge clk);
        #1;
        chk(hsil, 1'b0, "silence timer did not expire");
        $display("test silence timer done");
        end_of_test();
    end
endmodule // tb_top

`default_nettype wire
